// ---- shared/cpi_pkg.sv ----
// Constants, register map and carrier types for the crossbar port block.
// Assumes one system clock and an active-low asynchronous core reset.
package cpi_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int DATA_W = 8;
    localparam int ADDR_W = 6;
    localparam int PORT_MAX = 4;

    // ************************************************************
    // Register map: byte space below 0x20, bit space above
    // ************************************************************
    localparam logic [2:0] GRP_DATA = 3'h0;
    localparam logic [2:0] GRP_MODE = 3'h1;
    localparam logic [2:0] GRP_ALLOC = 3'h2;
    localparam logic [2:0] GRP_INDIR = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_DATA0 = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_MODE0 = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_ALLOC0 = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_INDIR0 = 6'h0C;
    localparam logic [ADDR_W-1:0] OFS_CFG_THIRD = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_BIT_BASE = 6'h20;
    localparam int BIT_SPACE_POS = 5;

    // ************************************************************
    // Field positions in the third crossbar configuration register
    // ************************************************************
    localparam int XBAR_EN_POS = 4;
    localparam int PULLUP_OFF_POS = 7;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [DATA_W-1:0] DATA_RST = 8'hFF;
    localparam logic [DATA_W-1:0] MODE_RST = 8'h00;
    localparam logic [DATA_W-1:0] ALLOC_RST = 8'h00;
    localparam logic [DATA_W-1:0] INDIR_RST = 8'h00;
    localparam logic [DATA_W-1:0] CFG_RST = 8'h00;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
        logic rmw;
    } cpi_bus_req_type;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] mode;
        logic [DATA_W-1:0] alloc;
        logic [DATA_W-1:0] indir;
    } cpi_port_cfg_type;

endpackage

// ---- rtl/cpi_port_cell.sv ----
// One byte-wide port: pin synchroniser and registered output drivers.
// Assumes pin_in arrives asynchronously and cfg comes from sys_clk flops.
module cpi_port_cell #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire cpi_pkg::cpi_port_cfg_type cfg,
    input wire logic xbar_en,
    input wire logic [WIDTH-1:0] periph_level,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    output logic [WIDTH-1:0] pin_level
);
    import cpi_pkg::*;

    logic [WIDTH-1:0] pin_meta;
    logic [WIDTH-1:0] src_level;
    logic [WIDTH-1:0] next_oe;
    logic [WIDTH-1:0] next_out;
    logic [WIDTH-1:0] pp_gpio;
    logic [WIDTH-1:0] od_gpio;
    logic [WIDTH-1:0] pp_periph;

    // ************************************************************
    // Pin synchroniser
    // ************************************************************
    // Two stages; only the second one is seen by any logic
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_meta <= '0;
            pin_level <= '0;
        end else begin
            pin_meta <= pin_in;
            pin_level <= pin_meta;
        end
    end

    // ************************************************************
    // Driver decision
    // ************************************************************
    // Allocated pins follow the peripheral, others the data latch
    always_comb begin
        src_level = (cfg.alloc & periph_level)
            | (~cfg.alloc & cfg.data);
        // Driver on only when crossbar is live and pin is not an input
        next_oe = {WIDTH{xbar_en}}
            & ~(cfg.alloc & cfg.indir);
        // Push-pull always drives; open-drain drives only a zero
        next_oe = next_oe
            & (cfg.mode | ~src_level);
        next_out = next_oe & cfg.mode & src_level;
    end

    // Registered so pins never glitch on decode changes
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_oe <= '0;
            pin_out <= '0;
        end else begin
            pin_oe <= next_oe;
            pin_out <= next_out;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    assign pp_gpio = ~cfg.alloc & cfg.mode;
    assign od_gpio = ~cfg.alloc & ~cfg.mode;
    assign pp_periph = cfg.alloc & ~cfg.indir & cfg.mode;

    a_push_pull_drive:
    assert property (@(posedge sys_clk) disable iff (!resetn)
        xbar_en |=> ((pin_oe & $past(pp_gpio)) == $past(pp_gpio))
            && ((pin_out & $past(pp_gpio))
                == ($past(cfg.data) & $past(pp_gpio))))
    else $error("push-pull pin not driven to its data bit");

    a_open_drain_drive:
    assert property (@(posedge sys_clk) disable iff (!resetn)
        xbar_en |=> ((pin_out & $past(od_gpio)) == '0)
            && ((pin_oe & $past(od_gpio))
                == (~$past(cfg.data) & $past(od_gpio))))
    else $error("open-drain pin drive wrong");

    a_input_pin_off:
    assert property (@(posedge sys_clk) disable iff (!resetn)
        ##1 ((pin_oe & $past(cfg.alloc & cfg.indir)) == '0))
    else $error("driver on for a peripheral input pin");

    a_periph_level_out:
    assert property (@(posedge sys_clk) disable iff (!resetn)
        xbar_en |=> ((pin_out & $past(pp_periph))
            == ($past(periph_level) & $past(pp_periph))))
    else $error("allocated pin does not follow peripheral");

endmodule

// ---- rtl/cpi_port_io.sv ----
// Crossbar-managed port I/O for byte-wide ports 0 to 3.
// Assumes a single-cycle register port on sys_clk and async pin levels.
module cpi_port_io #(
    parameter int PORTS = 4
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire cpi_pkg::cpi_bus_req_type bus_req,
    output logic [cpi_pkg::DATA_W-1:0] bus_rdata,
    input wire logic [PORTS*cpi_pkg::DATA_W-1:0] pin_in,
    output logic [PORTS*cpi_pkg::DATA_W-1:0] pin_out,
    output logic [PORTS*cpi_pkg::DATA_W-1:0] pin_oe,
    input wire logic [PORTS*cpi_pkg::DATA_W-1:0] periph_out,
    output logic [PORTS*cpi_pkg::DATA_W-1:0] periph_in,
    output logic pull_up_en,
    output logic xbar_active
);
    import cpi_pkg::*;

    // ************************************************************
    // Register state
    // ************************************************************
    logic [DATA_W-1:0] port_data [PORTS];
    logic [DATA_W-1:0] port_mode [PORTS];
    logic [DATA_W-1:0] port_alloc [PORTS];
    logic [DATA_W-1:0] port_indir [PORTS];
    logic [DATA_W-1:0] cfg_third;
    logic [DATA_W-1:0] pin_level [PORTS];
    cpi_port_cfg_type cell_cfg [PORTS];

    // ************************************************************
    // Address decode
    // ************************************************************
    logic in_bit_space;
    logic [2:0] grp;
    logic [1:0] pidx;
    logic [1:0] bport;
    logic [2:0] bsel;
    logic port_ok;
    logic bport_ok;
    logic cfg_sel;
    logic byte_data_sel;
    logic xbar_en;
    logic [DATA_W-1:0] next_rdata;
    logic [DATA_W-1:0] rd_pin_byte;
    logic [DATA_W-1:0] rd_latch_byte;
    logic [PORTS*DATA_W-1:0] mode_all;

    // Byte space splits into groups of four port registers
    assign in_bit_space = bus_req.addr[BIT_SPACE_POS];
    assign grp = bus_req.addr[4:2];
    assign pidx = bus_req.addr[1:0];
    assign bport = bus_req.addr[4:3];
    assign bsel = bus_req.addr[2:0];
    assign port_ok = int'(pidx) < PORTS;
    assign bport_ok = int'(bport) < PORTS;
    assign cfg_sel = (bus_req.addr == OFS_CFG_THIRD);
    assign byte_data_sel = !in_bit_space && (grp == GRP_DATA) && port_ok;

    // Crossbar enable gates every driver; pull-ups share one switch
    assign xbar_en = cfg_third[XBAR_EN_POS];
    assign xbar_active = xbar_en;
    assign pull_up_en = !cfg_third[PULLUP_OFF_POS];

    // ************************************************************
    // Port data latches
    // ************************************************************
    // Bit writes touch one latch bit; allocated pins ignore the latch
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < PORTS; i++) begin
                port_data[i] <= DATA_RST;
            end
        end else if (bus_req.wr) begin
            if (byte_data_sel) begin
                port_data[pidx] <= bus_req.wdata;
            end else if (in_bit_space && bport_ok) begin
                port_data[bport][bsel] <= bus_req.wdata[0];
            end
        end
    end

    // ************************************************************
    // Output mode registers
    // ************************************************************
    // Zero at reset keeps every pin open-drain until software decides
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < PORTS; i++) begin
                port_mode[i] <= MODE_RST;
            end
        end else if (bus_req.wr && !in_bit_space && port_ok) begin
            if (grp == GRP_MODE) begin
                port_mode[pidx] <= bus_req.wdata;
            end
        end
    end

    // ************************************************************
    // Crossbar control registers
    // ************************************************************
    // Allocation and input masks say which pins a peripheral owns
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < PORTS; i++) begin
                port_alloc[i] <= ALLOC_RST;
                port_indir[i] <= INDIR_RST;
            end
        end else if (bus_req.wr && !in_bit_space && port_ok) begin
            if (grp == GRP_ALLOC) begin
                port_alloc[pidx] <= bus_req.wdata;
            end else if (grp == GRP_INDIR) begin
                port_indir[pidx] <= bus_req.wdata;
            end
        end
    end

    // Enable and pull-up switch; changing routing live can glitch pins
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_third <= CFG_RST;
        end else if (bus_req.wr && cfg_sel) begin
            cfg_third <= bus_req.wdata;
        end
    end

    // ************************************************************
    // Per-port pin cells
    // ************************************************************
    // Peripherals see the same synchronised level that software reads
    for (genvar p = 0; p < PORTS; p++) begin : g_port
        assign cell_cfg[p] = '{data: port_data[p], mode: port_mode[p],
                               alloc: port_alloc[p], indir: port_indir[p]};
        assign periph_in[p*DATA_W +: DATA_W] = pin_level[p];
        assign mode_all[p*DATA_W +: DATA_W] = port_mode[p];

        cpi_port_cell #(
            .WIDTH(DATA_W)
        ) u_cell (
            .sys_clk(sys_clk),
            .resetn(resetn),
            .cfg(cell_cfg[p]),
            .xbar_en(xbar_en),
            .periph_level(periph_out[p*DATA_W +: DATA_W]),
            .pin_in(pin_in[p*DATA_W +: DATA_W]),
            .pin_out(pin_out[p*DATA_W +: DATA_W]),
            .pin_oe(pin_oe[p*DATA_W +: DATA_W]),
            .pin_level(pin_level[p])
        );
    end

    // ************************************************************
    // Read path
    // ************************************************************
    // Selected port byte, both as pin level and as stored latch
    always_comb begin
        rd_pin_byte = '0;
        rd_latch_byte = '0;
        if (port_ok) begin
            rd_pin_byte = pin_level[pidx];
            rd_latch_byte = port_data[pidx];
        end
    end

    // Plain reads see the pin, RMW reads see the latch
    always_comb begin
        next_rdata = '0;
        if (in_bit_space) begin
            if (bport_ok) begin
                next_rdata[0] = bus_req.rmw
                    ? port_data[bport][bsel]
                    : pin_level[bport][bsel];
            end
        end else if (cfg_sel) begin
            next_rdata = cfg_third;
        end else if (port_ok) begin
            case (grp)
                GRP_DATA: begin
                    // Pin levels lag writes by the output register plus the synchroniser depth
                    next_rdata = bus_req.rmw
                        ? rd_latch_byte
                        : rd_pin_byte;
                end
                GRP_MODE: begin
                    next_rdata = port_mode[pidx];
                end
                GRP_ALLOC: begin
                    next_rdata = port_alloc[pidx];
                end
                GRP_INDIR: begin
                    next_rdata = port_indir[pidx];
                end
                default: begin
                    next_rdata = '0;
                end
            endcase
        end
    end

    // Read data stand one cycle only, zero otherwise
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bus_rdata <= '0;
        end else if (bus_req.rd) begin
            bus_rdata <= next_rdata;
        end else begin
            bus_rdata <= '0;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_drivers_held_off:
    assert property (@(posedge sys_clk) disable iff (!resetn)
        !xbar_en |=> (pin_oe == '0))
    else $error("port driver on while crossbar disabled");

    a_pin_level_read:
    assert property (@(posedge sys_clk) disable iff (!resetn)
        (bus_req.rd && !bus_req.rmw && byte_data_sel)
            |=> (bus_rdata == $past(rd_pin_byte)))
    else $error("plain port read did not return pin level");

    a_rmw_latch_read:
    assert property (@(posedge sys_clk) disable iff (!resetn)
        (bus_req.rd && bus_req.rmw && byte_data_sel)
            |=> (bus_rdata == $past(rd_latch_byte)))
    else $error("read-modify-write read did not return latch");

    a_byte_write_store:
    assert property (@(posedge sys_clk) disable iff (!resetn)
        (bus_req.wr && byte_data_sel)
            |=> (port_data[$past(pidx)] == $past(bus_req.wdata)))
    else $error("byte write to port data lost");

    a_bit_write_store:
    assert property (@(posedge sys_clk) disable iff (!resetn)
        (bus_req.wr && in_bit_space && bport_ok)
            |=> (port_data[$past(bport)][$past(bsel)]
                == $past(bus_req.wdata[0])))
    else $error("bit write to port data lost");

    a_mode_reset_zero:
    assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(resetn) |-> (mode_all == '0))
    else $error("output mode not open-drain after reset");

    a_pin_sync_delay:
    assert property (@(posedge sys_clk) disable iff (!resetn)
        ##2 (!$past(resetn, 2)
            || (pin_level[0] == $past(pin_in[DATA_W-1:0], 2))))
    else $error("pin level not two cycles behind pin");

    a_read_one_cycle:
    assert property (@(posedge sys_clk) disable iff (!resetn)
        !bus_req.rd |=> (bus_rdata == '0))
    else $error("read data held past its cycle");

endmodule

// ---- test/cpi_board_model.sv ----
// Board model for the port pins: external drivers, pull-ups, floating lines.
// Assumes the port block drives pin_out and pin_oe from sys_clk flops.
module cpi_board_model #(
    parameter int WIDTH = 32
) (
    input wire logic sys_clk,
    input wire logic [WIDTH-1:0] pin_out,
    input wire logic [WIDTH-1:0] pin_oe,
    input wire logic pull_up_en,
    input wire logic [WIDTH-1:0] ext_oe,
    input wire logic [WIDTH-1:0] ext_val,
    output logic [WIDTH-1:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [WIDTH-1:0] last;

    // ************************************************************
    // Wire resolution
    // ************************************************************
    // Device driver wins, then board driver, then pull-up; a bare line
    // toggles so that a read of a floating pin never passes by luck
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            if (pin_oe[i]) begin
                pin_level[i] = pin_out[i];
            end else if (ext_oe[i]) begin
                pin_level[i] = ext_val[i];
            end else if (pull_up_en) begin
                pin_level[i] = 1'b1;
            end else begin
                pin_level[i] = ~last[i];
            end
        end
    end

    // Last level, used to make floating lines wander
    always_ff @(posedge sys_clk) begin
        last <= pin_level;
    end
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the crossbar port block.
// Assumes the board model of the pins and the one-cycle register port.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import cpi_pkg::*;

    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    cpi_bus_req_type bus_req = '0;
    logic [7:0] bus_rdata;
    logic [31:0] pin_in, pin_out, pin_oe, periph_in;
    logic [31:0] periph_out = '0;
    logic [31:0] ext_oe = '0;
    logic [31:0] ext_val = '0;
    logic pull_up_en, xbar_active;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    int errors = 0;
    int cmp_count = 0;

    // ************************************************************
    // Clock, design and board
    // ************************************************************
    // 100 MHz system clock
    always #5 sys_clk = ~sys_clk;

    cpi_port_io #(.PORTS(4)) i_cpi_port_io (
        .sys_clk(sys_clk), .resetn(resetn), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .periph_out(periph_out), .periph_in(periph_in),
        .pull_up_en(pull_up_en), .xbar_active(xbar_active)
    );

    cpi_board_model #(.WIDTH(32)) i_cpi_board_model (
        .sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_up_en(pull_up_en), .ext_oe(ext_oe), .ext_val(ext_val),
        .pin_level(pin_in)
    );

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One write cycle, then an idle cycle so strobes never double up
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, rmw: 1'b0};
        @(posedge sys_clk);
        bus_req <= '0;
        @(posedge sys_clk);
    endtask

    // Read cycle; the expected byte waits in the queue for the monitor
    task automatic rd(input logic [ADDR_W-1:0] a, input logic m,
                      input logic [7:0] e);
        exp_q.push_back(e);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, rmw: m};
        @(posedge sys_clk);
        bus_req <= '0;
        @(posedge sys_clk);
    endtask

    // Pins one step after the edge so registered drivers have landed
    task automatic pins(input int p, input logic [15:0] x);
        #1;
        chk("pin_oe", x[15:8], pin_oe[p*8 +: 8]);
        chk("pin_out", x[7:0], pin_out[p*8 +: 8]);
        @(posedge sys_clk);
    endtask

    // Expected driver enable and value of one port, high byte is enable
    function automatic logic [15:0] drive(input logic en,
        input logic [7:0] m, d, al, ind, per);
        logic [7:0] src, oe;
        src = (al & per) | (~al & d);
        oe = {8{en}} & ~(al & ind) & (m | ~src);
        return {oe, oe & m & src};
    endfunction

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge sys_clk) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) begin
                errors++;
                $display("[ERR] bus_rdata expected none seen %h", bus_rdata);
            end else begin
                chk("bus_rdata", exp_q.pop_front(), bus_rdata);
            end
        end
        rd_seen <= bus_req.rd;
    end

    // Watchdog, far beyond the roughly 150 cycles the tests need
    initial begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        print_verdict();
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        logic [7:0] v, m, e, per;
        void'($urandom(32'h8fdb));
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        // Reset state: drivers off, open-drain, latches high
        chk("xbar_active", 8'h00, {7'h00, xbar_active});
        chk("pull_up_en", 8'h01, {7'h00, pull_up_en});
        for (int p = 0; p < 4; p++) begin
            pins(p, 16'h0000);
            rd(OFS_MODE0 + ADDR_W'(p), 1'b0, MODE_RST);
            rd(OFS_DATA0 + ADDR_W'(p), 1'b0, 8'hFF);
            rd(OFS_DATA0 + ADDR_W'(p), 1'b1, DATA_RST);
        end
        $display("test reset finished");
        // Drivers held off until the enable bit is set, then push-pull
        v = 8'($urandom);
        wr(OFS_MODE0, 8'hFF);
        wr(OFS_DATA0, v);
        pins(0, 16'h0000);
        wr(OFS_CFG_THIRD, 8'h10);
        pins(0, {8'hFF, v});
        chk("xbar_active", 8'h01, {7'h00, xbar_active});
        $display("test enable finished");
        // Mixed modes per bit, then the level read back through pull-ups
        for (int k = 0; k < 4; k++) begin
            m = 8'($urandom);
            v = 8'($urandom);
            wr(OFS_MODE0 + 6'h01, m);
            wr(OFS_DATA0 + 6'h01, v);
            pins(1, drive(1'b1, m, v, 8'h00, 8'h00, 8'h00));
            repeat (3) @(posedge sys_clk);
            rd(OFS_DATA0 + 6'h01, 1'b0, v);
        end
        $display("test modes finished");
        // Board drives port 1; plain reads see pins, rmw sees latch
        wr(OFS_MODE0 + 6'h01, 8'h00);
        wr(OFS_DATA0 + 6'h01, 8'hFF);
        e = 8'($urandom);
        ext_oe[15:8] <= 8'hFF;
        ext_val[15:8] <= e;
        repeat (3) @(posedge sys_clk);
        rd(OFS_DATA0 + 6'h01, 1'b0, e);
        rd(OFS_DATA0 + 6'h01, 1'b1, 8'hFF);
        rd(OFS_BIT_BASE + 6'h0B, 1'b0, {7'h00, e[3]});
        rd(OFS_BIT_BASE + 6'h0B, 1'b1, 8'h01);
        chk("periph_in", e, periph_in[15:8]);
        ext_val[15:8] <= ~e;
        rd(OFS_DATA0 + 6'h01, 1'b0, e);
        repeat (3) @(posedge sys_clk);
        rd(OFS_DATA0 + 6'h01, 1'b0, ~e);
        ext_oe[15:8] <= 8'h00;
        $display("test pin_read finished");
        // Peripheral-owned pins on port 2, two of them peripheral inputs
        per = 8'($urandom);
        periph_out[23:16] <= per;
        wr(OFS_CFG_THIRD, 8'h00);
        wr(OFS_ALLOC0 + 6'h02, 8'hF0);
        wr(OFS_INDIR0 + 6'h02, 8'hC0);
        wr(OFS_MODE0 + 6'h02, 8'hFF);
        wr(OFS_DATA0 + 6'h02, 8'h00);
        wr(OFS_CFG_THIRD, 8'h10);
        pins(2, drive(1'b1, 8'hFF, 8'h00, 8'hF0, 8'hC0,
                      per));
        wr(OFS_DATA0 + 6'h02, 8'hFF);
        pins(2, drive(1'b1, 8'hFF, 8'hFF, 8'hF0, 8'hC0,
                      per));
        repeat (3) @(posedge sys_clk);
        rd(OFS_DATA0 + 6'h02, 1'b0, {2'b11, per[5:4], 4'hF});
        $display("test alloc finished");
        // Single-bit write leaves the rest of the port alone
        wr(OFS_MODE0 + 6'h03, 8'hFF);
        wr(OFS_DATA0 + 6'h03, 8'hFF);
        wr(OFS_BIT_BASE + 6'h1D, 8'hFE);
        pins(3, 16'hFFDF);
        rd(OFS_BIT_BASE + 6'h1D, 1'b1, 8'h00);
        rd(OFS_BIT_BASE + 6'h1C, 1'b1, 8'h01);
        rd(OFS_DATA0 + 6'h03, 1'b1, 8'hDF);
        $display("test bit_access finished");
        // Global pull-up switch, unmapped place, crossbar off again
        wr(OFS_CFG_THIRD, 8'h90);
        #1;
        chk("pull_up_en", 8'h00, {7'h00, pull_up_en});
        @(posedge sys_clk);
        rd(OFS_CFG_THIRD, 1'b0, 8'h90);
        rd(6'h15, 1'b0, 8'h00);
        wr(OFS_CFG_THIRD, 8'h00);
        pins(3, 16'h0000);
        pins(2, 16'h0000);
        $display("test global finished");
        repeat (3) @(posedge sys_clk);
        print_verdict();
    end
endmodule
